// file: rtl/cib_consts.vh
`ifndef CIB_CONSTS_VH
`define CIB_CONSTS_VH
// ==========================================
// Register selectors for the read port
`define CIB_SEL_OPCOND     3'h0
`define CIB_SEL_CARD_DATA  3'h1
`define CIB_SEL_CONFIG     3'h2
`define CIB_SEL_ADDR       3'h3
`define CIB_SEL_STATUS     3'h4
// ==========================================
// Operating-condition register
`define CIB_OPC_CLASS_BIT  30
`define CIB_OPC_READY_BIT  31
`define CIB_OPC_VDD_RESET  32'h01FF_8000
// ==========================================
// Card-specific data fields
`define CIB_DAT_WBL_HI     25
`define CIB_DAT_WBL_LO     22
`define CIB_DAT_WBL_VAL    4'h9
`define CIB_DAT_PARTIAL    21
`define CIB_DAT_FFG        15
`define CIB_DAT_COPY       14
`define CIB_DAT_PERM       13
`define CIB_DAT_TMP        12
`define CIB_DAT_FF_HI      11
`define CIB_DAT_FF_LO      10
`define CIB_DAT_RSV_HI     9
`define CIB_DAT_RSV_LO     8
`define CIB_DAT_CRC_HI     7
`define CIB_DAT_CRC_LO     1
`define CIB_DAT_END        0
`define CIB_DAT_SIZE_HI    69
`define CIB_DAT_SIZE_LO    48
`define CIB_DAT_MULTI_MASK 16'h1300
`define CIB_DAT_ONCE_MASK  16'hEC00
// Fixed upper part of the card-specific data, bits 127:70
`define CIB_DAT_TOP        58'h100_3800_C96D_6400
// Fixed bits 47:26 (erase, sector, write-protect group, speed factor)
`define CIB_DAT_MID        22'h1F_E002
// ==========================================
// Configuration register fields
`define CIB_CFG_STRUCT     4'h0
`define CIB_CFG_SPEC       4'h2
`define CIB_CFG_ERASE_VAL  1'b0
`define CIB_CFG_SECURITY   3'h0
`define CIB_CFG_BUSW       4'h5
`define CIB_CFG_SPEC3      1'b1
`define CIB_CFG_EXSEC      4'h0
`define CIB_CFG_SPEC4      1'b1
`define CIB_CFG_SPECX      4'h2
`define CIB_CFG_CMDSUP     4'h3
// ==========================================
// Status record fields
`define CIB_STA_BUS4       2'h2
`define CIB_STA_BUS1       2'h0
`define CIB_STA_SPEED      8'h04
`define CIB_STA_AU         4'h9
`define CIB_STA_EU_SIZE    16'h0008
`define CIB_STA_EU_TMO     6'h04
`define CIB_STA_EU_OFS     2'h1
`define CIB_STA_HS_G1      4'h1
`define CIB_STA_HS_G3      4'h3
`define CIB_STA_HS_AU      4'h9
`endif

// file: rtl/cib_crc7.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Checksum over 120 bits, polynomial x^7+x^3+1
module cib_crc7
(
  input  wire [119:0] data_in,
  output wire [6:0]   crc_out
);
  function [6:0] crc_step;
    input [6:0] c;
    input       b;
    reg         fb;
    begin
      fb = c[6] ^ b;
      crc_step = {c[5:3], c[2] ^ fb, c[1:0], fb};
    end
  endfunction

  wire [6:0] chain [0:120];
  assign chain[0] = 7'h00;
  genvar i;
  generate
    for (i = 0; i < 120; i = i + 1)
    begin : g_bit
      assign chain[i+1] = crc_step(chain[i], data_in[119-i]);
    end
  endgenerate
  assign crc_out = chain[120];
endmodule
`default_nettype wire

// file: rtl/cib_card_info_register_bank.v
`include "cib_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module cib_card_info_register_bank
#(
  parameter [21:0] DEVICE_SIZE   = 22'h00_1DFF,
  parameter        HIGH_CAPACITY = 1'b1,
  parameter        GRADE_THREE   = 1'b1,
  parameter [31:0] PROTECTED_SIZE = 32'h0000_0000
)
(
  input  wire         clock_in,
  input  wire         rst_in,
  input  wire         enable_in,
  input  wire         power_up_done_in,
  input  wire         addr_load_in,
  input  wire [15:0]  addr_value_in,
  input  wire         bus_width_four_in,
  input  wire         program_valid_in,
  input  wire [15:0]  program_data_in,
  input  wire [2:0]   read_select_in,
  output wire         program_ready_out,
  output reg          program_done_out,
  output reg          program_error_out,
  output reg  [511:0] read_data_out,
  output wire [21:0]  device_size_out,
  output wire [31:0]  capacity_kbytes_out
);
  // ==========================================
  // Power-up status
  reg        ready_reg;
  reg        ready_next;
  reg [15:0] addr_reg;
  reg [15:0] addr_next;

  always @*
  begin
    ready_next = ready_reg;
    if (power_up_done_in)
    begin
      ready_next = 1'b1;
    end
  end

  always @*
  begin
    addr_next = addr_reg;
    if (addr_load_in)
    begin
      addr_next = addr_value_in;
    end
  end

  // Capacity class forced low until ready, so an early read cannot mislead
  localparam [31:0] VDD_WORD = `CIB_OPC_VDD_RESET;
  wire        class_bit = ready_reg & HIGH_CAPACITY;
  wire [31:0] opcond_word;
  assign opcond_word[`CIB_OPC_READY_BIT] = ready_reg;
  assign opcond_word[`CIB_OPC_CLASS_BIT] = class_bit;
  // Voltage window bits are fixed; the card never renegotiates them
  assign opcond_word[29:0] = VDD_WORD[29:0];

  // ==========================================
  // Writable card-specific data, bits 15:8
  localparam ST_IDLE  = 2'h0;
  localparam ST_CRC   = 2'h1;
  localparam ST_DONE  = 2'h2;

  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [7:0]  field_reg;
  reg [7:0]  field_next;
  reg        once_used_reg;
  reg        once_used_next;
  reg [6:0]  crc_reg;
  reg [6:0]  crc_next;
  reg        done_next;
  reg        error_next;

  localparam [15:0] ONCE_MASK16  = `CIB_DAT_ONCE_MASK;
  localparam [15:0] MULTI_MASK16 = `CIB_DAT_MULTI_MASK;
  localparam [7:0]  ONCE_MASK    = ONCE_MASK16[15:8];
  localparam [7:0]  MULTI_MASK   = MULTI_MASK16[15:8];
  wire [7:0] req_field   = program_data_in[15:8];
  wire       once_change = |((req_field ^ field_reg) & ONCE_MASK);
  wire [7:0] field_merge;

  // Per-bit write gate; bits outside both masks keep their stored value
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1)
    begin : g_field
      assign field_merge[b] = (ONCE_MASK[b] | MULTI_MASK[b]) ? req_field[b] : field_reg[b];
    end
  endgenerate

  wire [127:0] data_body =
    {`CIB_DAT_TOP,
     DEVICE_SIZE,
     `CIB_DAT_MID,
     `CIB_DAT_WBL_VAL,
     1'b0,
     5'h00,
     field_reg,
     8'h00};
  wire [6:0] crc_calc;

  cib_crc7 u_crc
  (
    .data_in (data_body[127:8]),
    .crc_out (crc_calc)
  );

  assign program_ready_out = (state_reg == ST_IDLE);

  always @*
  begin
    state_next     = state_reg;
    field_next     = field_reg;
    once_used_next = once_used_reg;
    crc_next       = crc_reg;
    done_next      = 1'b0;
    error_next     = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (program_valid_in)
        begin
          if (once_change && once_used_reg)
          begin
            // Whole command refused, nothing partly applied
            error_next = 1'b1;
          end
          else
          begin
            field_next = field_merge;
            if (once_change)
            begin
              once_used_next = 1'b1;
            end
            state_next = ST_CRC;
          end
        end
      end
      ST_CRC:
      begin
        crc_next   = crc_calc;
        state_next = ST_DONE;
      end
      ST_DONE:
      begin
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  wire [127:0] data_word = {data_body[127:8], crc_reg, 1'b1};

  // ==========================================
  // Configuration register
  wire [63:0] config_word =
    {`CIB_CFG_STRUCT,
     `CIB_CFG_SPEC,
     `CIB_CFG_ERASE_VAL,
     `CIB_CFG_SECURITY,
     `CIB_CFG_BUSW,
     `CIB_CFG_SPEC3,
     `CIB_CFG_EXSEC,
     `CIB_CFG_SPEC4,
     `CIB_CFG_SPECX,
     2'b00,
     `CIB_CFG_CMDSUP,
     32'h0000_0000};

  // ==========================================
  // Status record
  wire [1:0]   bus_code = bus_width_four_in ? `CIB_STA_BUS4 : `CIB_STA_BUS1;
  wire [3:0]   grade    = GRADE_THREE ? `CIB_STA_HS_G3 : `CIB_STA_HS_G1;
  wire [511:0] status_word =
    {bus_code,
     1'b0,
     7'h00,
     6'h00,
     16'h0000,
     PROTECTED_SIZE,
     `CIB_STA_SPEED,
     8'h00,
     `CIB_STA_AU,
     4'h0,
     `CIB_STA_EU_SIZE,
     `CIB_STA_EU_TMO,
     `CIB_STA_EU_OFS,
     grade,
     `CIB_STA_HS_AU,
     392'h0};

  // ==========================================
  // Read mux, registered
  // Unknown selectors read zero rather than a stale word
  reg [511:0] read_next;
  always @*
  begin
    read_next = 512'h0;
    case (read_select_in)
      `CIB_SEL_OPCOND:
      begin
        read_next = {480'h0, opcond_word};
      end
      `CIB_SEL_CARD_DATA:
      begin
        read_next = {384'h0, data_word};
      end
      `CIB_SEL_CONFIG:
      begin
        read_next = {448'h0, config_word};
      end
      `CIB_SEL_ADDR:
      begin
        read_next = {496'h0, addr_reg};
      end
      `CIB_SEL_STATUS:
      begin
        read_next = status_word;
      end
      default:
      begin
        read_next = 512'h0;
      end
    endcase
  end

  // ==========================================
  // Capacity report
  // Widened before the add, so the largest size cannot wrap to zero
  wire [31:0] size_wide = {10'h000, DEVICE_SIZE};
  wire [31:0] size_plus = size_wide + 32'h0000_0001;
  assign device_size_out     = DEVICE_SIZE;
  assign capacity_kbytes_out = {size_plus[22:0], 9'h000};

  // ==========================================
  // Power-up register
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ready_reg <= 1'b0;
    end
    else if (enable_in)
    begin
      ready_reg <= ready_next;
    end
  end

  // Address kept apart: it is host state, not power state
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      addr_reg <= 16'h0000;
    end
    else if (enable_in)
    begin
      addr_reg <= addr_next;
    end
  end

  // ==========================================
  // Program sequencer registers
  // Reset enters the checksum state so the stored checksum is recomputed on the first cycle after reset
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_reg     <= ST_CRC;
      field_reg     <= 8'h00;
      once_used_reg <= 1'b0;
      crc_reg       <= 7'h00;
    end
    else if (enable_in)
    begin
      state_reg     <= state_next;
      field_reg     <= field_next;
      once_used_reg <= once_used_next;
      crc_reg       <= crc_next;
    end
  end

  // ==========================================
  // Program result pulses
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      program_done_out  <= 1'b0;
      program_error_out <= 1'b0;
    end
    else if (enable_in)
    begin
      program_done_out  <= done_next;
      program_error_out <= error_next;
    end
  end

  // ==========================================
  // Read port register
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      read_data_out <= 512'h0;
    end
    else if (enable_in)
    begin
      read_data_out <= read_next;
    end
  end
endmodule
`default_nettype wire

// file: tb/cib_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks
module cib_bank_sva
#(
  parameter [21:0] DEVICE_SIZE   = 22'h00_1DFF,
  parameter        HIGH_CAPACITY = 1'b1,
  parameter        GRADE_THREE   = 1'b1
)
(
  input wire         clock_in,
  input wire         rst_in,
  input wire         enable_in,
  input wire         power_up_done_in,
  input wire         bus_width_four_in,
  input wire         program_valid_in,
  input wire [2:0]   read_select_in,
  input wire         program_ready_out,
  input wire         program_done_out,
  input wire         program_error_out,
  input wire [511:0] read_data_out,
  input wire [21:0]  device_size_out,
  input wire [31:0]  capacity_kbytes_out
);
  reg  seen_reg;
  wire rd_opcond = enable_in && read_select_in == 3'h0;
  wire acc    = enable_in && program_valid_in && program_ready_out;
  // Sticky, so a late read still expects ready
  always @(posedge clock_in)
    seen_reg <= rst_in ? 1'b0 : (seen_reg | (enable_in & power_up_done_in));
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  AST_BUSY: assert property (rd_opcond && !seen_reg |=> read_data_out[31:30] == 2'h0)
    else $error("condition top bits set before power-up");
  AST_READY: assert property (rd_opcond && seen_reg |=> read_data_out[31:30] == {1'b1, HIGH_CAPACITY})
    else $error("condition ready or class bit wrong");
  AST_CARD_DATA: assert property (enable_in && read_select_in == 3'h1 |=> read_data_out[25:21] == 5'h12 && read_data_out[0])
    else $error("card data fixed fields wrong");
  AST_CONFIG: assert property (enable_in && read_select_in == 3'h2 |=> read_data_out[63:32] == 32'h0205_8483)
    else $error("configuration fields wrong");
  AST_STAT_BUS: assert property (enable_in && read_select_in == 3'h4 |=> read_data_out[511:510] == ($past(bus_width_four_in) ? 2'h2 : 2'h0))
    else $error("status bus width wrong");
  AST_STAT_GRADE: assert property (enable_in && read_select_in == 3'h4 |=> read_data_out[399:392] == {(GRADE_THREE ? 4'h3 : 4'h1), 4'h9})
    else $error("status speed grade wrong");
  AST_PROG: assert property (acc |=> program_error_out or (!program_ready_out [*2] ##1 program_done_out && program_ready_out))
    else $error("program sequence wrong");
  AST_CAP: assert property (device_size_out == DEVICE_SIZE && capacity_kbytes_out == ({10'h000, device_size_out} + 32'h0000_0001) * 32'h0000_0200)
    else $error("capacity wrong");
  cover property (acc ##1 program_error_out);
  cover property (acc ##3 program_done_out);
  cover property (rd_opcond && seen_reg);
endmodule
bind cib_card_info_register_bank cib_bank_sva #(.DEVICE_SIZE(DEVICE_SIZE),
  .HIGH_CAPACITY(HIGH_CAPACITY), .GRADE_THREE(GRADE_THREE)) u_sva (.clock_in(clock_in),
  .rst_in(rst_in), .enable_in(enable_in), .power_up_done_in(power_up_done_in),
  .bus_width_four_in(bus_width_four_in), .program_valid_in(program_valid_in),
  .read_select_in(read_select_in), .program_ready_out(program_ready_out),
  .program_done_out(program_done_out), .program_error_out(program_error_out),
  .read_data_out(read_data_out), .device_size_out(device_size_out),
  .capacity_kbytes_out(capacity_kbytes_out));
`default_nettype wire

// file: tb/cib_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host side: reads and program commands
module cib_host_model
(
  input  wire         clock_in,
  input  wire         ready_in,
  input  wire         done_in,
  input  wire         error_in,
  input  wire [511:0] data_in,
  output reg          valid_out,
  output reg  [15:0]  pdata_out,
  output reg  [2:0]   sel_out
);
  initial
  begin
    valid_out = 1'b0;
    pdata_out = 16'h0000;
    sel_out = 3'h0;
  end
  task rd(input [2:0] s, output [511:0] d);
  begin
    @(posedge clock_in);
    sel_out <= s;
    @(posedge clock_in);
    #1 d = data_in;
  end
  endtask
  task prog(input [15:0] v, output dn, output er);
    integer i;
  begin
    i = 0;
    @(posedge clock_in);
    valid_out <= 1'b1;
    pdata_out <= v;
    do
    begin
      @(posedge clock_in);
      i = i + 1;
    end
    while (ready_in !== 1'b1 && i < 20);
    valid_out <= 1'b0;
    // Released data is not left showing the last value
    pdata_out <= ~v;
    dn = 1'b0;
    er = 1'b0;
    repeat (5)
    begin
      #1 dn = dn | done_in;
      er = er | error_in;
      @(posedge clock_in);
    end
  end
  endtask
endmodule
`default_nettype wire

// file: tb/cib_card_info_register_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cib_consts.vh"
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin err_total = err_total + 1; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module cib_card_info_register_bank_tb;
  localparam [21:0]  SIZE = 22'h00_0FFF;
  // Bit 16 of each entry: refusal expected
  localparam [101:0] TBL = {17'h1_0000, 17'h1_6000, 17'h0_4000, 17'h0_4100, 17'h0_0100, 17'h0_1300};
  reg          clock_in = 1'b0;
  reg          rst_in = 1'b1;
  reg          pud = 1'b0;
  reg          load = 1'b0;
  reg  [15:0]  addr = 16'h0000;
  reg          bw4 = 1'b0;
  wire         pv;
  wire [15:0]  pd;
  wire [2:0]   sel;
  wire         rdy;
  wire         dn_w;
  wire         er_w;
  wire [511:0] rdat;
  wire [21:0]  size;
  wire [31:0]  cap;
  integer      err_total = 0;
  integer      checked = 0;
  integer      cyc = 0;
  integer      k;
  reg  [511:0] d;
  reg  [16:0]  ent;
  reg  [15:0]  cur;
  reg          dn;
  reg          er;
  cib_card_info_register_bank #(.DEVICE_SIZE(SIZE)) u_dut (.clock_in(clock_in), .rst_in(rst_in),
    .enable_in(1'b1), .power_up_done_in(pud), .addr_load_in(load), .addr_value_in(addr),
    .bus_width_four_in(bw4), .program_valid_in(pv), .program_data_in(pd), .read_select_in(sel),
    .program_ready_out(rdy), .program_done_out(dn_w), .program_error_out(er_w),
    .read_data_out(rdat), .device_size_out(size), .capacity_kbytes_out(cap));
  cib_host_model u_host (.clock_in(clock_in), .ready_in(rdy), .done_in(dn_w), .error_in(er_w),
    .data_in(rdat), .valid_out(pv), .pdata_out(pd), .sel_out(sel));
  function [6:0] crc7(input [119:0] c);
    integer i;
  begin
    crc7 = 7'h00;
    for (i = 119; i >= 0; i = i - 1)
      crc7 = {crc7[5:0], 1'b0} ^ ((crc7[6] ^ c[i]) ? 7'h09 : 7'h00);
  end
  endfunction
  function [127:0] img(input [15:0] low);
    reg [119:0] t;
  begin
    t = {`CIB_DAT_TOP, SIZE, `CIB_DAT_MID, 4'h9, 1'b0, 5'h00, low[15:8]};
    img = {t, crc7(t), 1'b1};
  end
  endfunction
  task close_out;
  begin
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  always #10 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      err_total = err_total + 1;
      close_out;
    end
  end
  initial
  begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    u_host.rd(3'h0, d);
    `CHK(d[31:30], 2'h0)
    u_host.rd(3'h2, d);
    `CHK(d, {448'h0, 64'h0205_8483_0000_0000})
    `CHK(cap, ({10'h000, SIZE} + 32'h0000_0001) * 32'h0000_0200)
    u_host.rd(3'h1, d);
    `CHK(d, {384'h0, img(16'h0000)})
    @(posedge clock_in);
    addr <= 16'hA5C3;
    load <= 1'b1;
    pud <= 1'b1;
    @(posedge clock_in);
    load <= 1'b0;
    pud <= 1'b0;
    u_host.rd(3'h3, d);
    `CHK(d, {496'h0, 16'hA5C3})
    u_host.rd(3'h0, d);
    `CHK(d, {480'h0, 32'hC1FF_8000})
    for (k = 0; k < 2; k = k + 1)
    begin
      @(posedge clock_in);
      bw4 <= k[0];
      u_host.rd(3'h4, d);
      `CHK(d[511:510], (k[0] ? 2'h2 : 2'h0))
      `CHK(d[399:392], 8'h39)
    end
    cur = 16'h0000;
    for (k = 0; k < 6; k = k + 1)
    begin
      ent = TBL[17*k +: 17];
      u_host.prog(ent[15:0], dn, er);
      `CHK({dn, er}, {~ent[16], ent[16]})
      if (!ent[16])
        cur = ent[15:0];
      u_host.rd(3'h1, d);
      `CHK(d, {384'h0, img(cur)})
    end
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    u_host.rd(3'h0, d);
    `CHK(d[31:30], 2'h0)
    u_host.rd(3'h1, d);
    `CHK(d, {384'h0, img(16'h0000)})
    close_out;
  end
endmodule
`default_nettype wire
